/* File: bench/prira_bench.sv */
`include "prira_defines.svh"
`default_nettype none
module prira_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import prira_pkg::*;
  // identity values are arbitrary
  localparam logic [15:0] TYPE_C = 16'h0A5C;
  localparam logic [15:0] FW_C   = 16'h3242;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  h_addr = 4'h0;
  prira_word_t h_wdata = 16'h0000;
  logic        h_wr = 1'b0;
  logic        h_rd = 1'b0;
  logic [15:0] h_rdata;
  logic [15:0] p_out;
  logic [6:0]  p_ctrl;
  logic        restart = 1'b0;
  logic [15:0] feat;
  prira_word_t d;
  int          fail_count = 0;
  int          tests_run = 0;
  prira_if     link ();
  always #5 clk = ~clk;
  prira_device #(.TYPE_ID(TYPE_C), .FW_VERSION(FW_C)) i_prira_device (
    .core_clk_in(clk), .rstn_in(rst_n), .link(link),
    .proc_in_word_in(16'h3C3C), .proc_status_in(7'h2A),
    .proc_out_word_out(p_out), .proc_ctrl_out(p_ctrl),
    .restart_in(restart), .feat_active_out(feat));
  prira_host i_prira_host (
    .core_clk_in(clk), .rstn_in(rst_n), .link(link),
    .reg_addr_in(h_addr), .reg_wdata_in(h_wdata), .reg_wr_in(h_wr),
    .reg_rd_in(h_rd), .reg_rdata_out(h_rdata));
  prira_chk #(.TYPE_ID(TYPE_C), .FW_VERSION(FW_C)) i_prira_chk (
    .core_clk_in(clk), .rstn_in(rst_n), .ctrl_byte(link.ctrl_byte),
    .out_data_hi(link.out_data_hi), .out_data_lo(link.out_data_lo),
    .status_byte(link.status_byte), .in_data_hi(link.in_data_hi),
    .in_data_lo(link.in_data_lo));
  task automatic end_of_test();
    $display("fails %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hw(input logic [3:0] a, input prira_word_t v);
    @(posedge clk);
    h_addr <= a;
    h_wdata <= v;
    h_wr <= 1'b1;
    @(posedge clk);
    h_wr <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output prira_word_t v);
    @(posedge clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge clk);
    h_rd <= 1'b0;
    @(negedge clk);
    v = h_rdata;
  endtask
  // one register access through the link, returning the host's last read word
  task automatic acc(input logic [6:0] cmd, input prira_word_t v,
                     output prira_word_t r);
    prira_word_t s;
    int          n;
    hw(`PRIRA_H_WDATA, v);
    hw(`PRIRA_H_CMD, {9'h000, cmd});
    s = 16'h0000;
    n = 0;
    while (s[1:0] !== 2'b10 && n < 50) begin
      hr(`PRIRA_H_STAT, s);
      n++;
    end
    chk({15'h0000, n >= 50}, 16'h0000);
    hr(`PRIRA_H_RDATA, r);
  endtask
  task automatic t_ident();
    acc(7'h08, 16'h0000, d);
    chk(d, TYPE_C);
    acc(7'h09, 16'hFFFF, d);
    chk(d, FW_C);
  endtask
  task automatic t_lock();
    acc(7'h1F, 16'h0000, d);
    chk(d, 16'h0000);
    acc(7'h61, 16'h5A5A, d);
    acc(7'h21, 16'h0000, d);
    chk(d, 16'h0000);
    acc(7'h48, 16'h1234, d);
    acc(7'h08, 16'h0000, d);
    chk(d, TYPE_C);
  endtask
  task automatic t_unlock();
    acc(7'h5F, 16'h1235, d);
    acc(7'h1F, 16'h0000, d);
    chk(d, 16'h1235);
    acc(7'h61, 16'hBEEF, d);
    acc(7'h21, 16'h0000, d);
    chk(d, 16'hBEEF);
    acc(7'h60, 16'h0002, d);
    acc(7'h20, 16'h0000, d);
    chk(d, 16'h0002);
    chk(feat, 16'h0106);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    @(negedge clk);
    chk(feat, 16'h0002);
    acc(7'h5F, 16'h0000, d);
    acc(7'h1F, 16'h0000, d);
    chk(d, 16'h0000);
    acc(7'h61, 16'h1111, d);
    acc(7'h21, 16'h0000, d);
    chk(d, 16'hBEEF);
  endtask
  task automatic t_proc();
    hw(`PRIRA_H_PROC_OUT, 16'hA55A);
    hw(`PRIRA_H_PROC_CTRL, 16'h0015);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(p_out, 16'hA55A);
    chk({9'h000, p_ctrl}, 16'h0015);
    hr(`PRIRA_H_PROC_IN, d);
    chk(d, 16'h3C3C);
    hr(4'hF, d);
    chk(d, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_ident();
    t_lock();
    t_unlock();
    t_proc();
    end_of_test();
  end
  initial begin
    #200us;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: bench/prira_chk.sv */
`default_nettype none
module prira_chk #(
  parameter logic [15:0] TYPE_ID    = 16'h0101,
  parameter logic [15:0] FW_VERSION = 16'h3130
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  // link
  input  wire logic [7:0] ctrl_byte,
  input  wire logic [7:0] out_data_hi,
  input  wire logic [7:0] out_data_lo,
  input  wire logic [7:0] status_byte,
  input  wire logic [7:0] in_data_hi,
  input  wire logic [7:0] in_data_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        open_q;
  logic [15:0] feat_q;
  logic [15:0] in_w;
  logic [15:0] out_w;
  assign in_w  = {in_data_hi, in_data_lo};
  assign out_w = {out_data_hi, out_data_lo};
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // shadow of lock state and feature register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_q <= 1'b0;
      feat_q <= 16'h0106;
    end else if (ctrl_byte == 8'hDF) begin
      open_q <= (out_w == 16'h1235);
    end else if (ctrl_byte == 8'hE0 && open_q) begin
      feat_q <= out_w;
    end
  end
  read_echo_a: assert property (ctrl_byte[7] && !ctrl_byte[6]
    |=> status_byte == $past(ctrl_byte)) else $error("bad read ack");
  write_ack_a: assert property (ctrl_byte[7] && ctrl_byte[6]
    |=> status_byte == ($past(ctrl_byte) & 8'hBF)) else $error("bad write ack");
  proc_mode_a: assert property (!ctrl_byte[7]
    |=> !status_byte[7]) else $error("status bit 7 in process mode");
  type_id_a: assert property (ctrl_byte == 8'h88
    |=> in_w == TYPE_ID) else $error("bad type word");
  fw_word_a: assert property (ctrl_byte == 8'h89
    |=> in_data_hi == FW_VERSION[15:8] && in_data_lo == FW_VERSION[7:0])
    else $error("bad version word");
  code_read_a: assert property (ctrl_byte == 8'h9F
    |=> in_w == (open_q ? 16'h1235 : 16'h0000)) else $error("bad code word");
  feat_read_a: assert property (ctrl_byte == 8'hA0
    |=> in_w == feat_q) else $error("bad feature word");
  read_hold_a: assert property (ctrl_byte[7] && !ctrl_byte[6]
    && $stable(ctrl_byte) |=> $stable(in_w)) else $error("read word moved");
endmodule
`default_nettype wire

/* File: src/prira_defines.svh */
`ifndef PRIRA_DEFINES_SVH
`define PRIRA_DEFINES_SVH

// control byte layout
`define PRIRA_REGMODE_BIT   7
`define PRIRA_WRITE_BIT     6
`define PRIRA_WRITE_MASK    8'h40
`define PRIRA_ADDR_MSB      5

// register numbers
`define PRIRA_TYPE_ADDR     6'h08
`define PRIRA_FW_ADDR       6'h09
`define PRIRA_CODE_ADDR     6'h1F
`define PRIRA_FEAT_ADDR     6'h20
`define PRIRA_PROT_LO       6'h10
`define PRIRA_PROT_HI       6'h2F

// values
`define PRIRA_CODE_UNLOCK   16'h1235
`define PRIRA_FEAT_RST      16'h0106

// host command port offsets
`define PRIRA_H_CMD         4'h0
`define PRIRA_H_WDATA       4'h1
`define PRIRA_H_STAT        4'h2
`define PRIRA_H_RDATA       4'h3
`define PRIRA_H_PROC_OUT    4'h4
`define PRIRA_H_PROC_IN     4'h5
`define PRIRA_H_PROC_CTRL   4'h6

// host status bits
`define PRIRA_H_BUSY_BIT    0
`define PRIRA_H_DONE_BIT    1

`endif

/* File: src/prira_device.sv */
// Contract
// - bit 7 set selects register access mode
// - read returns register word, contents unchanged
// - write stores output data word, then acknowledges
// - six low control bits address 64 registers
// - control/status byte first, word follows
// - word carried high byte first, low second
// - read acknowledged by echoing control byte
// - write acknowledged with write bit cleared
// - host ignores input word after write
// - output word ignored during register read
// - user area locked except code word register
// - unlock value in code register unlocks
// - any other code value relocks area
// - unlocked code register reads unlock value
// - locked code register reads zero
// - parameter changes act only after restart
// - register 9 returns firmware version characters
// - register 8 returns terminal type identifier
// - write to register 32 replaces features
//
// Local design decision: the plain strobed port.
`include "prira_defines.svh"
`default_nettype none
module prira_device #(
  // identity values are arbitrary
  parameter logic [15:0] TYPE_ID    = 16'h0101,
  parameter logic [15:0] FW_VERSION = 16'h3130
) (
  // clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               rstn_in,

  // link
  prira_if.dev                    link,

  // user side process data
  input  wire prira_pkg::prira_word_t proc_in_word_in,
  input  wire logic [6:0]         proc_status_in,
  output logic [15:0]             proc_out_word_out,
  output logic [6:0]              proc_ctrl_out,

  // restart and active configuration
  input  wire logic               restart_in,
  output logic [15:0]             feat_active_out
);
  import prira_pkg::*;

  prira_dev_state_t s_q;
  prira_dev_state_t s_d;

  // link fields
  prira_byte_t ctrl;
  prira_word_t word;
  prira_addr_t addr;
  logic        reg_mode;
  logic        wr;

  // access decode
  logic        acc_rd;
  logic        acc_wr;
  logic        unlocked;
  wire logic [63:0] wr_ok;
  logic [63:0] wr_hit;
  prira_word_t rd_val;
  prira_byte_t ack_byte;
  prira_word_t in_next;
  prira_word_t feat_next;

  // split the cyclic image into its fields
  always_comb begin
    ctrl     = link.ctrl_byte;
    word     = {link.out_data_hi, link.out_data_lo};
    addr     = ctrl[`PRIRA_ADDR_MSB:0];
    reg_mode = ctrl[`PRIRA_REGMODE_BIT];
    wr       = ctrl[`PRIRA_WRITE_BIT];
  end

  // register accesses only while register mode is selected
  always_comb begin
    acc_rd   = reg_mode && !wr;
    acc_wr   = reg_mode && wr;
    unlocked = (s_q.regs[`PRIRA_CODE_ADDR] == `PRIRA_CODE_UNLOCK);
  end

  // write permission of each register
  for (genvar i = 0; i < 64; i++) begin : g_wr_ok
    if (i == `PRIRA_CODE_ADDR) begin : g_code
      // the code word register stays writable while locked
      assign wr_ok[i] = 1'b1;
    end else if (i >= `PRIRA_PROT_LO && i <= `PRIRA_PROT_HI) begin : g_user
      assign wr_ok[i] = unlocked;
    end else begin : g_fixed
      assign wr_ok[i] = 1'b0;
    end
  end

  // one-hot write strobe of the addressed register
  always_comb begin
    wr_hit = '0;
    if (acc_wr) begin
      wr_hit[addr] = wr_ok[addr];
    end
  end

  // read value of the addressed register
  always_comb begin
    unique case (addr)
      `PRIRA_TYPE_ADDR: begin
        rd_val = TYPE_ID;
      end
      `PRIRA_FW_ADDR: begin
        rd_val = FW_VERSION;
      end
      `PRIRA_CODE_ADDR: begin
        if (unlocked) begin
          rd_val = s_q.regs[`PRIRA_CODE_ADDR];
        end else begin
          rd_val = 16'h0000;
        end
      end
      `PRIRA_FEAT_ADDR: begin
        rd_val = s_q.regs[`PRIRA_FEAT_ADDR];
      end
      default: begin
        rd_val = s_q.regs[addr];
      end
    endcase
  end

  // acknowledge byte for the status position
  always_comb begin
    unique case ({reg_mode, wr})
      2'b11: begin
        ack_byte = ctrl & ~`PRIRA_WRITE_MASK;
      end
      2'b10: begin
        ack_byte = ctrl;
      end
      default: begin
        ack_byte = {1'b0, proc_status_in};
      end
    endcase
  end

  // word shown in the input image next cycle
  always_comb begin
    if (acc_rd) begin
      // output word plays no part in a read
      in_next = rd_val;
    end else if (!reg_mode) begin
      in_next = proc_in_word_in;
    end else begin
      // after a write the old word stays; it is invalid there
      in_next = s_q.in_word;
    end
  end

  // stored parameters become active only on restart
  always_comb begin
    if (restart_in) begin
      feat_next = s_q.regs[`PRIRA_FEAT_ADDR];
    end else begin
      feat_next = s_q.feat_active;
    end
  end

  always_comb begin
    s_d             = s_q;
    s_d.status      = ack_byte;
    s_d.in_word     = in_next;
    s_d.feat_active = feat_next;
    // held writes repeat every cycle with the same value
    for (int i = 0; i < 64; i++) begin
      if (wr_hit[i]) begin
        s_d.regs[i] = word;
      end
    end
    // normal process data exchange
    if (!reg_mode) begin
      s_d.proc_out  = word;
      s_d.proc_ctrl = ctrl[6:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.regs[`PRIRA_FEAT_ADDR] <= `PRIRA_FEAT_RST;
      s_q.feat_active <= `PRIRA_FEAT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign link.status_byte = s_q.status;
  assign link.in_data_hi  = s_q.in_word[15:8];
  assign link.in_data_lo  = s_q.in_word[7:0];
  assign proc_out_word_out = s_q.proc_out;
  assign proc_ctrl_out     = s_q.proc_ctrl;
  assign feat_active_out   = s_q.feat_active;
endmodule
`default_nettype wire

/* File: src/prira_host.sv */
`include "prira_defines.svh"
`default_nettype none
module prira_host (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  // link
  prira_if.host                  link,
  // command port
  input  wire logic [3:0]        reg_addr_in,
  input  wire prira_pkg::prira_word_t reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [15:0]            reg_rdata_out
);
  import prira_pkg::*;

  prira_host_state_t s_q;
  prira_host_state_t s_d;
  prira_word_t       in_word;
  prira_byte_t       expect_ack;
  prira_word_t       stat_word;

  always_comb begin
    in_word = {link.in_data_hi, link.in_data_lo};
    if (s_q.ctrl[`PRIRA_WRITE_BIT]) begin
      expect_ack = s_q.ctrl & ~`PRIRA_WRITE_MASK;
    end else begin
      expect_ack = s_q.ctrl;
    end
    stat_word = '0;
    stat_word[`PRIRA_H_BUSY_BIT] = (s_q.st != PRIRA_H_IDLE);
    stat_word[`PRIRA_H_DONE_BIT] = s_q.done;
  end

  always_comb begin
    s_d = s_q;
    s_d.bus_rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `PRIRA_H_STAT:     s_d.bus_rdata = stat_word;
        `PRIRA_H_RDATA:    s_d.bus_rdata = s_q.rdata;
        `PRIRA_H_WDATA:    s_d.bus_rdata = s_q.wdata;
        `PRIRA_H_PROC_OUT: s_d.bus_rdata = s_q.proc_word;
        `PRIRA_H_PROC_IN:  s_d.bus_rdata = s_q.proc_in;
        `PRIRA_H_PROC_CTRL: s_d.bus_rdata = {9'h000, s_q.proc_ctrl};
        default:           s_d.bus_rdata = '0;
      endcase
    end
    if (reg_wr_in) begin
      if (reg_addr_in == `PRIRA_H_WDATA) begin
        s_d.wdata = reg_wdata_in;
      end
      if (reg_addr_in == `PRIRA_H_PROC_OUT) begin
        s_d.proc_word = reg_wdata_in;
      end
      if (reg_addr_in == `PRIRA_H_PROC_CTRL) begin
        s_d.proc_ctrl = reg_wdata_in[6:0];
      end
    end
    unique case (s_q.st)
      PRIRA_H_IDLE: begin
        s_d.ctrl     = {1'b0, s_d.proc_ctrl};
        s_d.out_word = s_d.proc_word;
        s_d.proc_in  = in_word;
        if (reg_wr_in && reg_addr_in == `PRIRA_H_CMD) begin
          s_d.ctrl = {1'b1, reg_wdata_in[6:0]};
          s_d.out_word = s_q.wdata;
          s_d.done = 1'b0;
          s_d.st   = PRIRA_H_WAIT;
        end
      end
      PRIRA_H_WAIT: begin
        // request held unchanged until its acknowledge
        if (link.status_byte == expect_ack) begin
          if (!s_q.ctrl[`PRIRA_WRITE_BIT]) begin
            s_d.rdata = in_word;
          end
          // after a write the input word is not taken
          s_d.done     = 1'b1;
          s_d.ctrl     = {1'b0, s_q.proc_ctrl};
          s_d.out_word = s_q.proc_word;
          s_d.st       = PRIRA_H_RELEASE;
        end
      end
      PRIRA_H_RELEASE: begin
        s_d.ctrl     = {1'b0, s_d.proc_ctrl};
        s_d.out_word = s_d.proc_word;
        if (!link.status_byte[`PRIRA_REGMODE_BIT]) begin
          s_d.st = PRIRA_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ctrl_byte   = s_q.ctrl;
  assign link.out_data_hi = s_q.out_word[15:8];
  assign link.out_data_lo = s_q.out_word[7:0];
  assign reg_rdata_out    = s_q.bus_rdata;
endmodule
`default_nettype wire

/* File: src/prira_if.sv */
`default_nettype none
interface prira_if;
  logic [7:0] ctrl_byte;
  logic [7:0] out_data_hi;
  logic [7:0] out_data_lo;
  logic [7:0] status_byte;
  logic [7:0] in_data_hi;
  logic [7:0] in_data_lo;

  modport dev (
    input  ctrl_byte,
    input  out_data_hi,
    input  out_data_lo,
    output status_byte,
    output in_data_hi,
    output in_data_lo
  );

  modport host (
    output ctrl_byte,
    output out_data_hi,
    output out_data_lo,
    input  status_byte,
    input  in_data_hi,
    input  in_data_lo
  );
endinterface
`default_nettype wire

/* File: src/prira_pkg.sv */
`default_nettype none
package prira_pkg;
  typedef logic [7:0]  prira_byte_t;
  typedef logic [15:0] prira_word_t;
  typedef logic [5:0]  prira_addr_t;

  typedef enum logic [1:0] {
    PRIRA_H_IDLE,
    PRIRA_H_WAIT,
    PRIRA_H_RELEASE
  } prira_hstate_t;

  typedef struct packed {
    prira_word_t [63:0] regs;
    prira_word_t        feat_active;
    prira_byte_t        status;
    prira_word_t        in_word;
    prira_word_t        proc_out;
    logic [6:0]         proc_ctrl;
  } prira_dev_state_t;

  typedef struct packed {
    prira_hstate_t st;
    prira_byte_t   ctrl;
    prira_word_t   out_word;
    prira_word_t   wdata;
    prira_word_t   rdata;
    prira_word_t   proc_word;
    logic [6:0]    proc_ctrl;
    prira_word_t   proc_in;
    logic          done;
    prira_word_t   bus_rdata;
  } prira_host_state_t;
endpackage
`default_nettype wire
